//--- rtl/dsp_fifo2.sv
`timescale 1ns/1ps

module dsp_fifo2
	import dsp_pkg::*;
(
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	// Filling side
	input  wire logic         inValid,
	input  dsp_wr_word_t      inWord,
	output logic              inReady,
	// Draining side
	output logic              outValid,
	output dsp_wr_word_t      outWord,
	input  wire logic         outReady
);

	dsp_wr_word_t entry_reg [2];
	logic         wrPtr_reg;
	logic         rdPtr_reg;
	logic [1:0]   count_reg;
	logic         push;
	logic         pop;

	assign inReady  = (count_reg != 2'h2);
	assign outValid = (count_reg != 2'h0);
	assign outWord  = entry_reg[rdPtr_reg];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			entry_reg[0] <= '0;
			entry_reg[1] <= '0;
		end else if (push) begin
			entry_reg[wrPtr_reg] <= inWord;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPtr_reg <= 1'b0;
			rdPtr_reg <= 1'b0;
			count_reg <= 2'h0;
		end else begin
			if (push)
				wrPtr_reg <= ~wrPtr_reg;
			if (pop)
				rdPtr_reg <= ~rdPtr_reg;
			if (push && !pop)
				count_reg <= count_reg + 2'h1;
			else if (pop && !push)
				count_reg <= count_reg - 2'h1;
		end
	end

endmodule : dsp_fifo2

//--- rtl/dsp_map.svh
`ifndef DSP_MAP_SVH
`define DSP_MAP_SVH

// ********************************************************
// Two-wire addressing
// ********************************************************
`define DSP_BUS_ADDR_HI       4'h9
`define DSP_LOW_BITS_STRAP_LO 3'h0
`define DSP_LOW_BITS_STRAP_FL 3'h2
`define DSP_LOW_BITS_STRAP_HI 3'h3
`define DSP_ADDR_HITS_LATCH   2'h1
`define DSP_PEC_POLY          8'h07
`define DSP_BYTE_LAST_BIT     3'h7
`define DSP_TIMEOUT_MS        25
`define DSP_CLK_PERIOD_NS     10

// ********************************************************
// Four-wire commands and pointer
// ********************************************************
`define DSP_CMD_WRITE         8'h90
`define DSP_CMD_READ          8'h91
`define DSP_PTR_FIRST         8'h00
`define DSP_PTR_LAST          8'h3f
`define DSP_LOCK_REG_ADDR     8'h7f
`define DSP_LOCK_PULSES_M1    2'h2

// ********************************************************
// Synchroniser bit positions and idle levels
// ********************************************************
`define DSP_PIN_CS            0
`define DSP_PIN_SCLK          1
`define DSP_PIN_DIN           2
`define DSP_PIN_SCL           3
`define DSP_PIN_SDA           4
`define DSP_PIN_STRAP0        5
`define DSP_PIN_STRAP1        6
`define DSP_PIN_IDLE          7'h1b

`endif

//--- rtl/dsp_pkg.sv
package dsp_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} dsp_wr_word_t;

	typedef enum logic [1:0] {
		DSP_STRAP_LOW,
		DSP_STRAP_FLOAT,
		DSP_STRAP_HIGH,
		DSP_STRAP_BAD
	} dsp_strap_t;

	typedef enum logic [2:0] {
		DSP_I2C_IDLE,
		DSP_I2C_ADDR,
		DSP_I2C_ADDR_ACK,
		DSP_I2C_WR,
		DSP_I2C_WR_ACK,
		DSP_I2C_RD,
		DSP_I2C_RD_ACK,
		DSP_I2C_WAIT
	} dsp_i2c_state_t;

	typedef enum logic [1:0] {
		DSP_SPI_NONE,
		DSP_SPI_WRITE,
		DSP_SPI_READ
	} dsp_spi_mode_t;

endpackage : dsp_pkg

//--- rtl/dsp_port.sv
// Behaviour
// - third chip-select rising edge locks four-wire mode.
// - once locked, two-wire traffic is ignored.
// - bus address upper four bits are 1001.
// - strap low/float/high gives low bits 000/010/011.
// - optional 25 ms inactivity timeout abandons transfer.
// - check byte is CRC-8, poly x8+x2+x+1.
// - start condition, then seven address bits, direction.
// - acknowledge own address; direction 0 write, 1 read.
// - nine clocks per byte, data changes clock-low.
// - direction fixed until a new start.
// - strap latched on second own-address transfer.
// - pointer-only write loads pointer, no data.
// - extra write bytes overwrite same register.
// - two-wire read returns one pointed byte.
// - first four-wire byte 90h writes, 91h reads.
// - four-wire input sampled on rising serial clock.
// - data pins released while chip select high.
// - four-wire write: command, address, then data.
// - four-wire pointer advances, wraps 3Fh to 00h.
// - powers up in two-wire mode, unlocked.
// - lock flag reads at 7Fh, power cycle clears.
// - four-wire read shifts out on falling clock.
`timescale 1ns/1ps
`include "dsp_map.svh"

module dsp_port
	import dsp_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = `DSP_TIMEOUT_MS * 1000000 / `DSP_CLK_PERIOD_NS
)
(
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	// Four-wire pins
	input  wire logic         csB,
	input  wire logic         sclk,
	input  wire logic         din,
	output logic              dout,
	output logic              doutOe,
	// Two-wire pins
	input  wire logic         scl,
	input  wire logic         sdaIn,
	output logic              sdaOut,
	output logic              sdaOe,
	// Address strap and configuration
	input  dsp_strap_t        addrStrap,
	input  wire logic         timeoutEn,
	output logic              spiLocked,
	// Register map side
	output logic [7:0]        regRdAddr,
	input  wire logic [7:0]   regRdData,
	output logic              regWrValid,
	output dsp_wr_word_t      regWrWord,
	input  wire logic         regWrReady
);

	// ********************************************************
	// Pin synchronisers and edge detection
	// ********************************************************
	logic [6:0] pinRaw;
	logic [6:0] pinMeta_reg;
	logic [6:0] pinSync_reg;
	logic [6:0] pinLast_reg;
	// Reset to the idle levels so that no false edge follows reset.
	localparam logic [6:0] PIN_IDLE = `DSP_PIN_IDLE;

	assign pinRaw = {addrStrap, sdaIn, scl, din, sclk, csB};

	generate
		for (genvar i = 0; i < 7; i++) begin : g_sync
			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					pinMeta_reg[i] <= PIN_IDLE[i];
					pinSync_reg[i] <= PIN_IDLE[i];
					pinLast_reg[i] <= PIN_IDLE[i];
				end else begin
					pinMeta_reg[i] <= pinRaw[i];
					pinSync_reg[i] <= pinMeta_reg[i];
					pinLast_reg[i] <= pinSync_reg[i];
				end
			end
		end
	endgenerate

	logic csS, sclkS, dinS, sclS, sdaS;
	logic csRise, csFall, sclkRise, sclkFall, sclRise, sclFall, i2cStart, i2cStop;
	dsp_strap_t strapS;

	assign csS      = pinSync_reg[`DSP_PIN_CS];
	assign sclkS    = pinSync_reg[`DSP_PIN_SCLK];
	assign dinS     = pinSync_reg[`DSP_PIN_DIN];
	assign sclS     = pinSync_reg[`DSP_PIN_SCL];
	assign sdaS     = pinSync_reg[`DSP_PIN_SDA];
	assign strapS   = dsp_strap_t'(pinSync_reg[`DSP_PIN_STRAP1:`DSP_PIN_STRAP0]);
	assign csRise   = csS && !pinLast_reg[`DSP_PIN_CS];
	assign csFall   = !csS && pinLast_reg[`DSP_PIN_CS];
	assign sclkRise = sclkS && !pinLast_reg[`DSP_PIN_SCLK];
	assign sclkFall = !sclkS && pinLast_reg[`DSP_PIN_SCLK];
	assign sclRise  = sclS && !pinLast_reg[`DSP_PIN_SCL];
	assign sclFall  = !sclS && pinLast_reg[`DSP_PIN_SCL];
	// Both lines go through identical stages, so their relative order is kept.
	assign i2cStart = sclS && pinLast_reg[`DSP_PIN_SCL] && !sdaS && pinLast_reg[`DSP_PIN_SDA];
	assign i2cStop  = sclS && pinLast_reg[`DSP_PIN_SCL] && sdaS && !pinLast_reg[`DSP_PIN_SDA];

	// ********************************************************
	// Interface selection and lock
	// ********************************************************
	logic [1:0] csPulses_reg;
	logic       locked_reg;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			csPulses_reg <= 2'h0;
			locked_reg   <= 1'b0;
		end else if (!locked_reg && csRise) begin
			csPulses_reg <= csPulses_reg + 2'h1;
			if (csPulses_reg == `DSP_LOCK_PULSES_M1)
				locked_reg <= 1'b1;
		end
	end

	assign spiLocked = locked_reg;

	// ********************************************************
	// Shared pointer, read data and write buffer
	// ********************************************************
	logic [7:0]   ptr_reg;
	logic [7:0]   ptrNext;
	logic [7:0]   rdByte;
	logic         i2cPush_reg;
	logic         spiPush_reg;
	dsp_wr_word_t i2cWord_reg;
	dsp_wr_word_t spiWord_reg;
	logic         bufReady;

	assign regRdAddr = ptr_reg;
	// The lock flag lives here, so the rest of the map cannot shadow it.
	assign rdByte  = (ptr_reg == `DSP_LOCK_REG_ADDR) ? {7'h0, locked_reg} : regRdData;
	assign ptrNext = (ptr_reg == `DSP_PTR_LAST) ? `DSP_PTR_FIRST : ptr_reg + 8'h01;

	dsp_fifo2 i_dsp_fifo2 (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.inValid  (locked_reg ? spiPush_reg : i2cPush_reg),
		.inWord   (locked_reg ? spiWord_reg : i2cWord_reg),
		.inReady  (bufReady),
		.outValid (regWrValid),
		.outWord  (regWrWord),
		.outReady (regWrReady)
	);

	function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc;
		for (int i = 7; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ data[i]) ? `DSP_PEC_POLY : 8'h00);
		end
		return c;
	endfunction : crc8

	// ********************************************************
	// Two-wire inactivity timeout
	// ********************************************************
	logic [31:0]    idleCnt_reg;
	logic           timedOut;
	dsp_i2c_state_t i2cState_reg;

	assign timedOut = timeoutEn && (idleCnt_reg == 32'(TIMEOUT_CYCLES - 1));

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			idleCnt_reg <= '0;
		else if (i2cState_reg == DSP_I2C_IDLE || sclRise || sclFall || timedOut)
			idleCnt_reg <= '0;
		else if (pinLast_reg[`DSP_PIN_SDA] != sdaS)
			idleCnt_reg <= '0;
		else
			idleCnt_reg <= idleCnt_reg + 32'h1;
	end

	// ********************************************************
	// Two-wire address strap latch
	// ********************************************************
	logic [1:0] addrHits_reg;
	logic       strapHeld_reg;
	dsp_strap_t strapKept_reg;
	dsp_strap_t strapUse;
	logic [2:0] lowBits;
	logic [7:0] rxByte;
	logic       addrHit;
	logic [7:0] rxShift_reg;
	logic [2:0] i2cBit_reg;

	assign strapUse = strapHeld_reg ? strapKept_reg : strapS;
	assign rxByte   = {rxShift_reg[6:0], sdaS};
	assign addrHit  = (rxByte[7:1] == {`DSP_BUS_ADDR_HI, lowBits});

	always_comb begin
		unique case (strapUse)
			DSP_STRAP_LOW:  lowBits = `DSP_LOW_BITS_STRAP_LO;
			DSP_STRAP_HIGH: lowBits = `DSP_LOW_BITS_STRAP_HI;
			default:        lowBits = `DSP_LOW_BITS_STRAP_FL;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			addrHits_reg  <= 2'h0;
			strapHeld_reg <= 1'b0;
			strapKept_reg <= DSP_STRAP_LOW;
		end else if (i2cState_reg == DSP_I2C_ADDR && sclRise && !locked_reg
				&& i2cBit_reg == `DSP_BYTE_LAST_BIT && addrHit && !strapHeld_reg) begin
			addrHits_reg <= addrHits_reg + 2'h1;
			if (addrHits_reg == `DSP_ADDR_HITS_LATCH) begin
				strapHeld_reg <= 1'b1;
				strapKept_reg <= strapS;
			end
		end
	end

	// ********************************************************
	// Two-wire byte engine
	// ********************************************************
	logic       ackPhase_reg;
	logic       ackGo_reg;
	logic       readDir_reg;
	logic       firstWr_reg;
	logic       pecSent_reg;
	logic [7:0] crc_reg;
	logic [7:0] txShift_reg;
	logic [7:0] spiPtrWr;
	logic       spiPtrLoad;
	logic       spiPtrStep;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			i2cState_reg <= DSP_I2C_IDLE;
			i2cBit_reg   <= 3'h0;
			rxShift_reg  <= 8'h00;
			txShift_reg  <= 8'h00;
			ackPhase_reg <= 1'b0;
			ackGo_reg    <= 1'b0;
			readDir_reg  <= 1'b0;
			firstWr_reg  <= 1'b0;
			pecSent_reg  <= 1'b0;
			crc_reg      <= 8'h00;
			sdaOe        <= 1'b0;
			i2cPush_reg  <= 1'b0;
			i2cWord_reg  <= '0;
		end else begin
			i2cPush_reg <= 1'b0;
			if (locked_reg || i2cStop || timedOut) begin
				i2cState_reg <= DSP_I2C_IDLE;
				sdaOe        <= 1'b0;
			end else if (i2cStart) begin
				i2cState_reg <= DSP_I2C_ADDR;
				i2cBit_reg   <= 3'h0;
				crc_reg      <= 8'h00;
				pecSent_reg  <= 1'b0;
				sdaOe        <= 1'b0;
			end else begin
				unique case (i2cState_reg)
					DSP_I2C_IDLE, DSP_I2C_WAIT: sdaOe <= 1'b0;
					DSP_I2C_ADDR, DSP_I2C_WR: if (sclRise) begin
						rxShift_reg <= rxByte;
						i2cBit_reg  <= i2cBit_reg + 3'h1;
						if (i2cBit_reg == `DSP_BYTE_LAST_BIT) begin
							crc_reg      <= crc8(crc_reg, rxByte);
							ackPhase_reg <= 1'b0;
							if (i2cState_reg == DSP_I2C_ADDR) begin
								readDir_reg  <= rxByte[0];
								firstWr_reg  <= 1'b1;
								i2cState_reg <= addrHit ? DSP_I2C_ADDR_ACK : DSP_I2C_WAIT;
							end else begin
								firstWr_reg  <= 1'b0;
								ackGo_reg    <= firstWr_reg || bufReady;
								i2cState_reg <= DSP_I2C_WR_ACK;
								if (!firstWr_reg && bufReady) begin
									i2cPush_reg <= 1'b1;
									i2cWord_reg <= '{addr: ptr_reg, data: rxByte};
								end
							end
						end
					end
					DSP_I2C_ADDR_ACK, DSP_I2C_WR_ACK: if (sclFall) begin
						ackPhase_reg <= 1'b1;
						if (!ackPhase_reg) begin
							sdaOe <= (i2cState_reg == DSP_I2C_ADDR_ACK) || ackGo_reg;
						end else if (i2cState_reg == DSP_I2C_ADDR_ACK && readDir_reg) begin
							sdaOe        <= !rdByte[7];
							txShift_reg  <= {rdByte[6:0], 1'b0};
							crc_reg      <= crc8(crc_reg, rdByte);
							i2cBit_reg   <= 3'h1;
							i2cState_reg <= DSP_I2C_RD;
						end else begin
							sdaOe        <= 1'b0;
							i2cBit_reg   <= 3'h0;
							i2cState_reg <= DSP_I2C_WR;
						end
					end
					DSP_I2C_RD: if (sclFall) begin
						i2cBit_reg <= i2cBit_reg + 3'h1;
						if (i2cBit_reg == 3'h0) begin
							sdaOe        <= 1'b0;
							ackPhase_reg <= 1'b0;
							i2cState_reg <= DSP_I2C_RD_ACK;
						end else begin
							sdaOe       <= !txShift_reg[7];
							txShift_reg <= {txShift_reg[6:0], 1'b0};
						end
					end
					DSP_I2C_RD_ACK: begin
						if (sclRise)
							ackPhase_reg <= !sdaS;
						if (sclFall) begin
							// A master acknowledge here asks for the check byte, once.
							if (ackPhase_reg && !pecSent_reg) begin
								pecSent_reg  <= 1'b1;
								sdaOe        <= !crc_reg[7];
								txShift_reg  <= {crc_reg[6:0], 1'b0};
								i2cBit_reg   <= 3'h1;
								i2cState_reg <= DSP_I2C_RD;
							end else begin
								i2cState_reg <= DSP_I2C_WAIT;
							end
						end
					end
				endcase
			end
		end
	end

	assign sdaOut = 1'b0;

	// ********************************************************
	// Pointer ownership
	// ********************************************************
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			ptr_reg <= `DSP_PTR_FIRST;
		else if (spiPtrLoad)
			ptr_reg <= spiPtrWr;
		else if (spiPtrStep)
			ptr_reg <= ptrNext;
		else if (!locked_reg && i2cState_reg == DSP_I2C_WR && sclRise
				&& i2cBit_reg == `DSP_BYTE_LAST_BIT && firstWr_reg)
			ptr_reg <= rxByte;
	end

	// ********************************************************
	// Four-wire engine
	// ********************************************************
	dsp_spi_mode_t spiMode_reg;
	logic [2:0]    spiBit_reg;
	logic [1:0]    spiByte_reg;
	logic [7:0]    spiShift_reg;
	logic [7:0]    spiTx_reg;
	logic [7:0]    spiByte;
	logic          spiByteDone;

	assign spiByte     = {spiShift_reg[6:0], dinS};
	assign spiByteDone = locked_reg && !csS && sclkRise && spiBit_reg == `DSP_BYTE_LAST_BIT;
	assign spiPtrLoad  = spiByteDone && spiMode_reg == DSP_SPI_WRITE && spiByte_reg == 2'h1;
	assign spiPtrStep  = spiByteDone && ((spiMode_reg == DSP_SPI_WRITE && spiByte_reg == 2'h2)
			|| spiMode_reg == DSP_SPI_READ
			|| (spiByte_reg == 2'h0 && spiByte == `DSP_CMD_READ));
	assign spiPtrWr    = spiByte;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			spiMode_reg  <= DSP_SPI_NONE;
			spiBit_reg   <= 3'h0;
			spiByte_reg  <= 2'h0;
			spiShift_reg <= 8'h00;
			spiTx_reg    <= 8'h00;
			spiPush_reg  <= 1'b0;
			spiWord_reg  <= '0;
			dout         <= 1'b1;
		end else begin
			spiPush_reg <= 1'b0;
			if (!locked_reg || csS || csFall) begin
				spiBit_reg  <= 3'h0;
				spiByte_reg <= 2'h0;
				spiMode_reg <= DSP_SPI_NONE;
			end else if (sclkRise) begin
				spiShift_reg <= spiByte;
				spiBit_reg   <= spiBit_reg + 3'h1;
				if (spiByteDone) begin
					if (spiByte_reg != 2'h2)
						spiByte_reg <= spiByte_reg + 2'h1;
					if (spiByte_reg == 2'h0) begin
						unique case (spiByte)
							`DSP_CMD_WRITE: spiMode_reg <= DSP_SPI_WRITE;
							`DSP_CMD_READ:  spiMode_reg <= DSP_SPI_READ;
							default:        spiMode_reg <= DSP_SPI_NONE;
						endcase
					end
					if (spiMode_reg == DSP_SPI_WRITE && spiByte_reg == 2'h2) begin
						// The serial clock cannot be held off, so a full buffer drops the byte.
						spiPush_reg <= bufReady;
						spiWord_reg <= '{addr: ptr_reg, data: spiByte};
					end
					if (spiMode_reg == DSP_SPI_READ || (spiByte_reg == 2'h0 && spiByte == `DSP_CMD_READ))
						spiTx_reg <= rdByte;
				end
			end else if (sclkFall) begin
				dout      <= spiTx_reg[7];
				spiTx_reg <= {spiTx_reg[6:0], 1'b0};
			end
		end
	end

	assign doutOe = locked_reg && !csS;

endmodule : dsp_port

//--- test/dsp_host_model.sv
`timescale 1ns/1ps

module dsp_host_model (
	// Four-wire pins
	output logic              csB,
	output logic              sclk,
	output logic              din,
	input  wire logic         dout,
	// Two-wire pins
	output logic              scl,
	output logic              sdaIn,
	input  wire logic         sdaOe
);
	localparam realtime Q = 31.25;
	logic sdaDrv;
	// The line has a pull-up, so it is low whenever either party pulls it.
	assign sdaIn = sdaDrv & ~sdaOe;
	initial begin
		csB    = 1'b1;
		sclk   = 1'b1;
		din    = 1'b1;
		scl    = 1'b1;
		sdaDrv = 1'b1;
	end

	// ********************************************************
	// Two-wire master
	// ********************************************************
	task automatic i2cStart();
		sdaDrv = 1'b1;
		#Q scl = 1'b1;
		#Q sdaDrv = 1'b0;
		#Q scl = 1'b0;
		#Q;
	endtask : i2cStart
	task automatic i2cStop();
		sdaDrv = 1'b0;
		#Q scl = 1'b1;
		#Q sdaDrv = 1'b1;
		#Q;
	endtask : i2cStop
	task automatic i2cBit(input logic b, output logic s);
		sdaDrv = b;
		#Q scl = 1'b1;
		#Q s = sdaIn;
		#Q scl = 1'b0;
		#Q;
	endtask : i2cBit
	// Sends b MSB first (all ones to read), then ackIn in the ninth clock.
	task automatic i2cByte(input logic [7:0] b, input logic ackIn,
		output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) i2cBit(b[i], r[i]);
		i2cBit(ackIn, ack);
	endtask : i2cByte

	// ********************************************************
	// Four-wire master
	// ********************************************************
	task automatic csPulse();
		csB = 1'b0;
		#(2*Q) csB = 1'b1;
		#(2*Q);
	endtask : csPulse
	task automatic spiFrame(input logic on);
		#(2*Q) csB = !on;
		din = 1'b1;
		#(4*Q);
	endtask : spiFrame
	task automatic spiByte(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			sclk = 1'b0;
			din = b[i];
			#(2*Q) r[i] = dout;
			sclk = 1'b1;
			#(2*Q);
		end
	endtask : spiByte
endmodule : dsp_host_model

//--- test/dsp_port_sva.sv
`timescale 1ns/1ps

module dsp_port_sva
	import dsp_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = 200
)
(
	// Clock and reset
	input wire logic          core_clk,
	input wire logic          rst_b,
	// Four-wire pins
	input wire logic          csB,
	input wire logic          sclk,
	input wire logic          din,
	input wire logic          dout,
	input wire logic          doutOe,
	// Two-wire pins
	input wire logic          scl,
	input wire logic          sdaIn,
	input wire logic          sdaOut,
	input wire logic          sdaOe,
	// Strap and configuration
	input dsp_strap_t         addrStrap,
	input wire logic          timeoutEn,
	input wire logic          spiLocked,
	// Register map side
	input wire logic [7:0]    regRdAddr,
	input wire logic [7:0]    regRdData,
	input wire logic          regWrValid,
	input dsp_wr_word_t       regWrWord,
	input wire logic          regWrReady
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	// Counts cycles without any edge on the two-wire lines.
	logic sclReg;
	logic sdaReg;
	int   idleReg;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sclReg  <= 1'b1;
			sdaReg  <= 1'b1;
			idleReg <= 0;
		end else begin
			sclReg  <= scl;
			sdaReg  <= sdaIn;
			idleReg <= (scl != sclReg || sdaIn != sdaReg) ? 0 : idleReg + 1;
		end
	end

	sequence s_cs_idle;
		csB [*4];
	endsequence
	sequence s_locked_run;
		spiLocked [*4];
	endsequence

	chk_reset_state: assert property ($rose(rst_b) |-> !spiLocked && !doutOe && !sdaOe
		&& regRdAddr == 8'h00 && !regWrValid) else $error("outputs not idle after reset");
	chk_lock_sticky: assert property (spiLocked |=> spiLocked)
		else $error("lock flag dropped");
	chk_oe_needs_lock: assert property (doutOe |-> spiLocked)
		else $error("data out driven while unlocked");
	chk_oe_cs_high: assert property (s_cs_idle |-> !doutOe)
		else $error("data out driven with chip select high");
	chk_locked_quiet: assert property (s_locked_run |-> !sdaOe)
		else $error("two-wire line pulled while locked");
	chk_wr_hold: assert property (regWrValid && !regWrReady |=> regWrValid && $stable(regWrWord))
		else $error("buffered word lost or changed");
	chk_timeout_drop: assert property (timeoutEn && idleReg > TIMEOUT_CYCLES + 8 |-> !sdaOe)
		else $error("transfer not abandoned after timeout");
	chk_sda_scl_low: assert property ($changed(sdaOe) |-> !scl)
		else $error("data line changed while clock high");
	chk_dout_fall: assert property (spiLocked && $changed(dout) |-> !sclk)
		else $error("data out changed while serial clock high");
	chk_wr_cs_low: assert property ($rose(regWrValid) && spiLocked |-> !csB)
		else $error("four-wire write outside a transfer");
endmodule : dsp_port_sva

bind dsp_port dsp_port_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_dsp_port_sva (
	.core_clk(core_clk), .rst_b(rst_b), .csB(csB), .sclk(sclk), .din(din), .dout(dout),
	.doutOe(doutOe), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
	.addrStrap(addrStrap), .timeoutEn(timeoutEn), .spiLocked(spiLocked),
	.regRdAddr(regRdAddr), .regRdData(regRdData), .regWrValid(regWrValid),
	.regWrWord(regWrWord), .regWrReady(regWrReady));

//--- test/dual_serial_register_port_tb_top.sv
`timescale 1ns/1ps

module dual_serial_register_port_tb_top
	import dsp_pkg::*;
;
	localparam int TMO = 200;
	logic core_clk, rst_b, csB, sclk, din, dout, doutOe, scl, sdaIn, sdaOe, timeoutEn;
	logic spiLocked, regWrValid, regWrReady;
	logic [7:0] regRdAddr, regRdData, rb;
	dsp_strap_t addrStrap;
	dsp_wr_word_t regWrWord;
	int nFail = 0;
	int checked = 0;
	logic a;

	assign regRdData = regRdAddr ^ 8'h3c;
	dsp_port #(.TIMEOUT_CYCLES(TMO)) i_dsp_port (.core_clk(core_clk), .rst_b(rst_b),
		.csB(csB), .sclk(sclk), .din(din), .dout(dout), .doutOe(doutOe), .scl(scl),
		.sdaIn(sdaIn), .sdaOut(), .sdaOe(sdaOe), .addrStrap(addrStrap),
		.timeoutEn(timeoutEn), .spiLocked(spiLocked), .regRdAddr(regRdAddr),
		.regRdData(regRdData), .regWrValid(regWrValid), .regWrWord(regWrWord),
		.regWrReady(regWrReady));
	dsp_host_model i_dsp_host_model (.csB(csB), .sclk(sclk), .din(din), .dout(dout),
		.scl(scl), .sdaIn(sdaIn), .sdaOe(sdaOe));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// ********************************************************
	// Comparisons and helpers
	// ********************************************************
	task automatic fail(input string m);
		nFail++;
		$display("[ERR] %0t %s", $time, m);
	endtask : fail
	task automatic chkBit(input logic g, input logic e);
		checked++;
		if (g !== e) fail($sformatf("bit got %b want %b", g, e));
	endtask : chkBit
	task automatic chkByte(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) fail($sformatf("byte got %h want %h", g, e));
	endtask : chkByte
	task automatic chkWord(input dsp_wr_word_t g, input dsp_wr_word_t e);
		checked++;
		if (g !== e) fail($sformatf("word got %h want %h", g, e));
	endtask : chkWord
	task automatic wrapUp();
		$display("compares %0d mismatches %0d", checked, nFail);
		if (nFail == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrapUp
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc8
	task automatic doReset();
		@(negedge core_clk) rst_b = 1'b0;
		repeat (12) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (4) @(negedge core_clk);
		chkBit(spiLocked, 1'b0);
		chkBit(sdaOe | doutOe | regWrValid, 1'b0);
		chkByte(regRdAddr, 8'h00);
	endtask : doReset
	task automatic sendByte(input logic [7:0] b, input logic expAck);
		i_dsp_host_model.i2cByte(b, 1'b1, rb, a);
		chkBit(a, expAck);
	endtask : sendByte
	// Pops one buffered word, bounded wait on valid.
	task automatic popWord(input dsp_wr_word_t e);
		@(negedge core_clk);
		for (int n = 0; n < 100 && regWrValid !== 1'b1; n++) @(negedge core_clk);
		chkWord(regWrWord, e);
		regWrReady = 1'b1;
		@(negedge core_clk) regWrReady = 1'b0;
	endtask : popWord

	// ********************************************************
	// Scenarios
	// ********************************************************
	task automatic tStrapLevels();
		dsp_strap_t lv[3] = '{DSP_STRAP_LOW, DSP_STRAP_HIGH, DSP_STRAP_FLOAT};
		logic [2:0] lb[3] = '{3'h0, 3'h3, 3'h2};
		for (int i = 0; i < 3; i++) begin
			doReset();
			addrStrap = lv[i];
			repeat (4) @(negedge core_clk);
			i_dsp_host_model.i2cStart();
			sendByte({4'h9, lb[i] ^ 3'h1, 1'b0}, 1'b1);
			i_dsp_host_model.i2cStop();
			i_dsp_host_model.i2cStart();
			sendByte({4'h9, lb[i], 1'b0}, 1'b0);
			i_dsp_host_model.i2cStop();
		end
	endtask : tStrapLevels
	task automatic tI2cWrite();
		i_dsp_host_model.i2cStart();
		sendByte(8'h94, 1'b0);
		sendByte(8'h12, 1'b0);
		i_dsp_host_model.i2cStop();
		chkByte(regRdAddr, 8'h12);
		chkBit(regWrValid, 1'b0);
		i_dsp_host_model.i2cStart();
		sendByte(8'h94, 1'b0);
		sendByte(8'h12, 1'b0);
		sendByte(8'h5a, 1'b0);
		sendByte(8'ha5, 1'b0);
		sendByte(8'h77, 1'b1);
		i_dsp_host_model.i2cStop();
		chkByte(regRdAddr, 8'h12);
		popWord({8'h12, 8'h5a});
		popWord({8'h12, 8'ha5});
		chkBit(regWrValid, 1'b0);
	endtask : tI2cWrite
	task automatic tI2cRead();
		@(negedge core_clk) addrStrap = DSP_STRAP_HIGH;
		i_dsp_host_model.i2cStart();
		sendByte(8'h96, 1'b1);
		i_dsp_host_model.i2cStart();
		sendByte(8'h95, 1'b0);
		i_dsp_host_model.i2cByte(8'hff, 1'b0, rb, a);
		chkByte(rb, 8'h12 ^ 8'h3c);
		i_dsp_host_model.i2cByte(8'hff, 1'b1, rb, a);
		chkByte(rb, crc8({8'h95, 8'h12 ^ 8'h3c}));
		i_dsp_host_model.i2cStop();
		chkByte(regRdAddr, 8'h12);
	endtask : tI2cRead
	task automatic tTimeout();
		@(negedge core_clk) timeoutEn = 1'b1;
		i_dsp_host_model.i2cStart();
		for (int i = 7; i >= 0; i--) i_dsp_host_model.i2cBit(i == 7 || i == 4 || i == 2, a);
		@(negedge core_clk);
		chkBit(sdaOe, 1'b1);
		repeat (TMO + 60) @(negedge core_clk);
		chkBit(sdaOe, 1'b0);
		i_dsp_host_model.i2cStop();
		timeoutEn = 1'b0;
	endtask : tTimeout
	task automatic tLock();
		repeat (2) i_dsp_host_model.csPulse();
		repeat (10) @(negedge core_clk);
		chkBit(spiLocked, 1'b0);
		i_dsp_host_model.csPulse();
		repeat (10) @(negedge core_clk);
		chkBit(spiLocked, 1'b1);
		chkBit(doutOe, 1'b0);
		i_dsp_host_model.i2cStart();
		sendByte(8'h94, 1'b1);
		i_dsp_host_model.i2cStop();
	endtask : tLock
	task automatic tSpi();
		logic [7:0] wb[4] = '{8'h90, 8'h3f, 8'h11, 8'h22};
		i_dsp_host_model.spiFrame(1'b1);
		foreach (wb[i]) i_dsp_host_model.spiByte(wb[i], rb);
		i_dsp_host_model.spiFrame(1'b0);
		popWord({8'h3f, 8'h11});
		popWord({8'h00, 8'h22});
		chkByte(regRdAddr, 8'h01);
		i_dsp_host_model.spiFrame(1'b1);
		i_dsp_host_model.spiByte(8'h91, rb);
		chkBit(doutOe, 1'b1);
		i_dsp_host_model.spiByte(8'h00, rb);
		chkByte(rb, 8'h01 ^ 8'h3c);
		i_dsp_host_model.spiByte(8'h00, rb);
		chkByte(rb, 8'h02 ^ 8'h3c);
		i_dsp_host_model.spiFrame(1'b0);
		i_dsp_host_model.spiFrame(1'b1);
		i_dsp_host_model.spiByte(8'h90, rb);
		i_dsp_host_model.spiByte(8'h7f, rb);
		i_dsp_host_model.spiFrame(1'b0);
		i_dsp_host_model.spiFrame(1'b1);
		i_dsp_host_model.spiByte(8'h91, rb);
		i_dsp_host_model.spiByte(8'h00, rb);
		chkByte(rb, 8'h01);
		i_dsp_host_model.spiFrame(1'b0);
	endtask : tSpi

	initial begin
		rst_b = 1'b0;
		addrStrap = DSP_STRAP_LOW;
		timeoutEn = 1'b0;
		regWrReady = 1'b0;
		tStrapLevels();
		tI2cWrite();
		tI2cRead();
		tTimeout();
		tLock();
		tSpi();
		wrapUp();
	end
	initial begin
		#300us;
		fail("watchdog expired");
		wrapUp();
	end
endmodule : dual_serial_register_port_tb_top
